// *** rtl/pfs_pkg.sv ***
// pfs_pkg: constants shared by the pin function select block.
// Assumes an 8-bit register port with 16-bit byte addresses.
package pfs_pkg;

	// pin count and pin indices (port 1 pins 1..7, port 2 pins 0..3)
	localparam int PFS_NPIN = 11;
	localparam int PFS_P1_1 = 0;
	localparam int PFS_P1_2 = 1;
	localparam int PFS_P1_3 = 2;
	localparam int PFS_P1_4 = 3;
	localparam int PFS_P1_5 = 4;
	localparam int PFS_P1_6 = 5;
	localparam int PFS_P1_7 = 6;
	localparam int PFS_P2_0 = 7;
	localparam int PFS_P2_1 = 8;
	localparam int PFS_P2_2 = 9;
	localparam int PFS_P2_3 = 10;

	// register port widths
	localparam int PFS_AW = 16;
	localparam int PFS_DW = 8;

	typedef logic [PFS_DW-1:0] pfs_byte_t;
	typedef logic [PFS_NPIN-1:0] pfs_pins_t;

	// byte addresses of the per-pin function registers, by pin index
	localparam logic [PFS_AW-1:0] PFS_REG_OFF [PFS_NPIN] = '{
		16'hA059, 16'hA05A, 16'hA05B, 16'hA05C, 16'hA05D, 16'hA05E,
		16'hA05F, 16'hA070, 16'hA071, 16'hA072, 16'hA073
	};

	// implemented bits per register; the rest read zero and ignore writes
	localparam pfs_byte_t PFS_REG_MASK [PFS_NPIN] = '{
		8'h07, 8'h07, 8'h07, 8'h01, 8'h01, 8'h0F,
		8'h0F, 8'h03, 8'h03, 8'h03, 8'h83
	};

	// reset value of every function register
	localparam pfs_byte_t PFS_REG_RST = 8'h00;

	// field positions
	localparam int PFS_B_GENERAL_IO = 0;
	localparam int PFS_B_ADC_D4 = 1;
	localparam int PFS_B_CAPTURE_CH1 = 2;
	localparam int PFS_B_I2C_SLAVE = 1;
	localparam int PFS_B_I2C_MASTER = 2;
	localparam int PFS_B_PIN_IRQ = 1;
	localparam int PFS_B_IRQ_EDGE = 2;
	localparam int PFS_B_TIMER_IN = 3;
	localparam int PFS_B_ALT = 1;
	localparam int PFS_B_VOLTAGE_DAC = 7;

	// analog enable value in the separate pin I/O configuration register
	localparam pfs_byte_t PFS_IOCFG_ANALOG = 8'h08;

endpackage : pfs_pkg

// *** rtl/pfs_sync_if.sv ***
// pfs_sync_if: synchronised pin levels and edges passed to the mux.
// Assumes both ends sit on the same clk.
`timescale 1ns/1ps
`default_nettype none
interface pfs_sync_if;
	import pfs_pkg::*;

	pfs_pins_t level;
	pfs_pins_t rise;
	pfs_pins_t fall;

	modport sync (output level, output rise, output fall);
	modport mux (input level, input rise, input fall);
endinterface : pfs_sync_if
`default_nettype wire

// *** rtl/pfs_pin_sync.sv ***
// pfs_pin_sync: two-flop synchronisers and edge detection for the pins.
// Assumes pin levels are asynchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_sync
	import pfs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// raw pad levels
	input wire pfs_pins_t pin_raw,
	// synchronised view
	pfs_sync_if.sync sy
);

	pfs_pins_t meta_reg;
	pfs_pins_t stable_reg;
	pfs_pins_t prev_reg;

	// first stage only feeds the second; edges are taken after stage two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			stable_reg <= '0;
			prev_reg <= '0;
		end else begin
			meta_reg <= pin_raw;
			stable_reg <= meta_reg;
			prev_reg <= stable_reg;
		end
	end

	// per-pin edge decode
	genvar i;
	generate
		for (i = 0; i < PFS_NPIN; i++) begin : g_edge
			assign sy.rise[i] = stable_reg[i] & ~prev_reg[i];
			assign sy.fall[i] = ~stable_reg[i] & prev_reg[i];
		end
	endgenerate

	assign sy.level = stable_reg;

endmodule : pfs_pin_sync
`default_nettype wire

// *** rtl/pfs_pin_mux.sv ***
// pfs_pin_mux: function select registers and pin mux for eleven pins.
// Assumes a one-cycle register port and peripherals on the same clk;
// pad levels arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux
	import pfs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [PFS_AW-1:0] addr,
	input wire pfs_byte_t wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [PFS_DW-1:0] rd_data,
	// pin io configuration bits, per pin
	input wire pfs_pins_t analog_path_enable,
	input wire pfs_pins_t open_drain_enable,
	// pads
	input wire pfs_pins_t pad_in,
	output pfs_pins_t pad_out,
	output pfs_pins_t pad_oe_n,
	// general io block
	input wire pfs_pins_t general_io_out,
	input wire pfs_pins_t general_io_drive,
	output pfs_pins_t general_io_in,
	// capture compare channel 1
	input wire logic capture_compare_ch1_out,
	input wire logic capture_compare_ch1_drive,
	output logic capture_compare_ch1_in,
	// i2c master and slave, data and clock, open drain style
	input wire logic i2c_master_data_out,
	input wire logic i2c_master_data_drive,
	output logic i2c_master_data_in,
	input wire logic i2c_slave_data_out,
	input wire logic i2c_slave_data_drive,
	output logic i2c_slave_data_in,
	input wire logic i2c_master_clock_out,
	input wire logic i2c_master_clock_drive,
	output logic i2c_master_clock_in,
	input wire logic i2c_slave_clock_out,
	input wire logic i2c_slave_clock_drive,
	output logic i2c_slave_clock_in,
	// timers
	output logic timer1_input,
	output logic timer0_input,
	// pin interrupt lines
	output logic pin_irq_line_a,
	output logic pin_irq_line_b,
	output logic pin_irq_line_d,
	// second uart
	input wire logic uart2_transmit,
	output logic uart2_receive,
	// analog connections
	output logic adc_d4_connect,
	output logic crystal_input_connect,
	output logic crystal_output_connect,
	output logic voltage_dac_connect,
	output pfs_pins_t comparator_connect
);

	pfs_sync_if sy ();

	pfs_byte_t func_reg [PFS_NPIN];
	pfs_byte_t rd_data_reg;
	logic [PFS_NPIN-1:0] hit;
	pfs_pins_t drv_val_next;
	pfs_pins_t drv_en_next;
	pfs_pins_t func_idle;
	pfs_pins_t pad_out_reg;
	pfs_pins_t pad_oe_n_reg;
	pfs_pins_t general_io_in_reg;
	pfs_pins_t comparator_reg;
	logic cc1_in_reg;
	logic m_sda_reg;
	logic s_sda_reg;
	logic m_scl_reg;
	logic s_scl_reg;
	logic t1_reg;
	logic t0_reg;
	logic irq_a_reg;
	logic irq_b_reg;
	logic irq_d_reg;
	logic rx2_reg;
	logic adc_reg;
	logic xin_reg;
	logic crystal_output_reg;
	logic dac_reg;

	// pad levels are asynchronous, so they go through two flops first
	pfs_pin_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin_raw(pad_in),
		.sy(sy.sync)
	);

	// address decode and register storage, one entry per pin
	genvar i;
	generate
		for (i = 0; i < PFS_NPIN; i++) begin : g_reg
			assign hit[i] = (addr == PFS_REG_OFF[i]);
			assign func_idle[i] = (func_reg[i] == PFS_REG_RST);
			// masked write keeps unused bits zero
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					func_reg[i] <= PFS_REG_RST;
				end else if (wr_en && hit[i]) begin
					func_reg[i] <= wr_data & PFS_REG_MASK[i];
				end
			end
		end
	endgenerate

	// read data stands in the cycle after the strobe only
	// read back as stored; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= '0;
		end else if (rd_en) begin
			rd_data_reg <= '0;
			for (int k = 0; k < PFS_NPIN; k++) begin
				if (hit[k]) begin
					rd_data_reg <= func_reg[k];
				end
			end
		end else begin
			rd_data_reg <= '0;
		end
	end

	// drive selection per pin; a pin with no drive source is released.
	// two bits set at once is illegal for software, here capture, i2c and uart2
	// transmit override general io, so a stale io bit cannot steal those pins
	// one-hot selection assumed
	always_comb begin
		drv_val_next = '0;
		drv_en_next = '0;
		for (int k = 0; k < PFS_NPIN; k++) begin
			if (func_reg[k][PFS_B_GENERAL_IO]) begin
				drv_val_next[k] = general_io_out[k];
				drv_en_next[k] = general_io_drive[k];
			end
		end
		if (func_reg[PFS_P1_1][PFS_B_CAPTURE_CH1]) begin
			drv_val_next[PFS_P1_1] = capture_compare_ch1_out;
			drv_en_next[PFS_P1_1] = capture_compare_ch1_drive;
		end
		if (func_reg[PFS_P1_2][PFS_B_I2C_MASTER]) begin
			drv_val_next[PFS_P1_2] = i2c_master_data_out;
			drv_en_next[PFS_P1_2] = i2c_master_data_drive;
		end else if (func_reg[PFS_P1_2][PFS_B_I2C_SLAVE]) begin
			drv_val_next[PFS_P1_2] = i2c_slave_data_out;
			drv_en_next[PFS_P1_2] = i2c_slave_data_drive;
		end
		if (func_reg[PFS_P1_3][PFS_B_I2C_MASTER]) begin
			drv_val_next[PFS_P1_3] = i2c_master_clock_out;
			drv_en_next[PFS_P1_3] = i2c_master_clock_drive;
		end else if (func_reg[PFS_P1_3][PFS_B_I2C_SLAVE]) begin
			drv_val_next[PFS_P1_3] = i2c_slave_clock_out;
			drv_en_next[PFS_P1_3] = i2c_slave_clock_drive;
		end
		// uart2 transmit always drives when selected
		if (func_reg[PFS_P2_2][PFS_B_ALT]) begin
			drv_val_next[PFS_P2_2] = uart2_transmit;
			drv_en_next[PFS_P2_2] = 1'b1;
		end
	end

	// pad drivers; open drain only pulls low, so a high means released.
	// software owns the open-drain bit for i2c pins, the mux just obeys it
	// open drain honoured
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_out_reg <= '0;
			pad_oe_n_reg <= '1;
		end else begin
			for (int k = 0; k < PFS_NPIN; k++) begin
				pad_out_reg[k] <= drv_val_next[k] & ~open_drain_enable[k];
				pad_oe_n_reg[k] <= ~(drv_en_next[k] &
					~(open_drain_enable[k] & drv_val_next[k]));
			end
		end
	end

	// general io input view, zero when the io function is off
	// pins 1.4 and 1.5 io only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			general_io_in_reg <= '0;
		end else begin
			for (int k = 0; k < PFS_NPIN; k++) begin
				general_io_in_reg[k] <= sy.level[k] & func_reg[k][PFS_B_GENERAL_IO];
			end
		end
	end

	// digital peripheral inputs, each gated by its own select bit
	// unselected inputs see zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cc1_in_reg <= 1'b0;
			m_sda_reg <= 1'b0;
			s_sda_reg <= 1'b0;
			m_scl_reg <= 1'b0;
			s_scl_reg <= 1'b0;
			rx2_reg <= 1'b0;
		end else begin
			cc1_in_reg <= sy.level[PFS_P1_1] & func_reg[PFS_P1_1][PFS_B_CAPTURE_CH1];
			m_sda_reg <= sy.level[PFS_P1_2] & func_reg[PFS_P1_2][PFS_B_I2C_MASTER];
			s_sda_reg <= sy.level[PFS_P1_2] & func_reg[PFS_P1_2][PFS_B_I2C_SLAVE];
			m_scl_reg <= sy.level[PFS_P1_3] & func_reg[PFS_P1_3][PFS_B_I2C_MASTER];
			s_scl_reg <= sy.level[PFS_P1_3] & func_reg[PFS_P1_3][PFS_B_I2C_SLAVE];
			rx2_reg <= sy.level[PFS_P2_3] & func_reg[PFS_P2_3][PFS_B_ALT];
		end
	end

	// timer external inputs follow the pin level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			t1_reg <= 1'b0;
			t0_reg <= 1'b0;
		end else begin
			t1_reg <= sy.level[PFS_P1_6] & func_reg[PFS_P1_6][PFS_B_TIMER_IN];
			t0_reg <= sy.level[PFS_P1_7] & func_reg[PFS_P1_7][PFS_B_TIMER_IN];
		end
	end

	// pin interrupts a and b: one-cycle pulse on the chosen edge; the edge bit
	// alone does nothing, so a stray edge setting cannot fire a line
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_a_reg <= 1'b0;
			irq_b_reg <= 1'b0;
			irq_d_reg <= 1'b0;
		end else begin
			irq_a_reg <= func_reg[PFS_P1_6][PFS_B_PIN_IRQ] &
				(func_reg[PFS_P1_6][PFS_B_IRQ_EDGE] ?
				sy.rise[PFS_P1_6] : sy.fall[PFS_P1_6]);
			irq_b_reg <= func_reg[PFS_P1_7][PFS_B_PIN_IRQ] &
				(func_reg[PFS_P1_7][PFS_B_IRQ_EDGE] ?
				sy.rise[PFS_P1_7] : sy.fall[PFS_P1_7]);
			// line d is a level, the interrupt unit picks the edge
			irq_d_reg <= sy.level[PFS_P2_3] & func_reg[PFS_P2_3][PFS_B_ALT];
		end
	end

	// analog and oscillator connections are levels to the analog macros.
	// the analog enable is software's job; adc and dac connect only with it
	// so a forgotten enable leaves the path open rather than half-driven
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_reg <= 1'b0;
			xin_reg <= 1'b0;
			crystal_output_reg <= 1'b0;
			dac_reg <= 1'b0;
			comparator_reg <= '0;
		end else begin
			adc_reg <= func_reg[PFS_P1_1][PFS_B_ADC_D4] & analog_path_enable[PFS_P1_1];
			xin_reg <= func_reg[PFS_P2_0][PFS_B_ALT];
			crystal_output_reg <= func_reg[PFS_P2_1][PFS_B_ALT];
			dac_reg <= func_reg[PFS_P2_3][PFS_B_VOLTAGE_DAC] & analog_path_enable[PFS_P2_3];
			// comparator when function is all zero
			comparator_reg <= func_idle & analog_path_enable;
		end
	end

	// outputs straight from flops
	assign rd_data = rd_data_reg;
	assign pad_out = pad_out_reg;
	assign pad_oe_n = pad_oe_n_reg;
	assign general_io_in = general_io_in_reg;
	assign capture_compare_ch1_in = cc1_in_reg;
	assign i2c_master_data_in = m_sda_reg;
	assign i2c_slave_data_in = s_sda_reg;
	assign i2c_master_clock_in = m_scl_reg;
	assign i2c_slave_clock_in = s_scl_reg;
	assign timer1_input = t1_reg;
	assign timer0_input = t0_reg;
	assign pin_irq_line_a = irq_a_reg;
	assign pin_irq_line_b = irq_b_reg;
	assign pin_irq_line_d = irq_d_reg;
	assign uart2_receive = rx2_reg;
	assign adc_d4_connect = adc_reg;
	assign crystal_input_connect = xin_reg;
	assign crystal_output_connect = crystal_output_reg;
	assign voltage_dac_connect = dac_reg;
	assign comparator_connect = comparator_reg;

endmodule : pfs_pin_mux
`default_nettype wire

// *** tb/pfs_pad_model.sv ***
// pfs_pad_model: the pads with an outside source behind each pin.
// Assumes the bench sets the level that each released pin floats to.
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_model
	import pfs_pkg::*;
(
	// mux side
	input wire pfs_pins_t pad_out,
	input wire pfs_pins_t pad_oe_n,
	// outside world
	input wire pfs_pins_t ext_level,
	output var pfs_pins_t pad_in
);
	// released pin follows outside
	// a driven pin reads back its own value, so no pull is assumed here
	assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule : pfs_pad_model
`default_nettype wire

// *** tb/pfs_pin_mux_asserts.sv ***
// pfs_pin_mux_asserts: port checks for the pin function select block.
// Assumes a one-cycle read port and registered mux outputs.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux_asserts
	import pfs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [PFS_AW-1:0] addr,
	input wire logic rd_en,
	input wire logic [PFS_DW-1:0] rd_data,
	// mux side
	input wire pfs_pins_t analog_path_enable,
	input wire pfs_pins_t pad_oe_n,
	input wire pfs_pins_t comparator_connect,
	input wire logic pin_irq_line_a,
	input wire logic pin_irq_line_b,
	input wire logic adc_d4_connect,
	input wire logic voltage_dac_connect
);
	// one domain; reset silences every check
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	reset_release_a: assert property ($rose(rst_n) |-> pad_oe_n == 11'h7FF)
		else $error("pads driven after reset");
	rd_idle_a: assert property (!rd_en |=> rd_data == 8'h00)
		else $error("read data without a read");
	unmapped_rd_a: assert property (rd_en && (addr < 16'hA059 || addr > 16'hA073)
		|=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	io_only_a: assert property (rd_en && (addr == 16'hA05C || addr == 16'hA05D)
		|=> rd_data[7:1] == 7'h00)
		else $error("unused bits set on io only pin");
	dac_mask_a: assert property (rd_en && addr == 16'hA073 |=> rd_data[6:2] == 5'h00)
		else $error("unused bits set on pin 2.3");
	irq_a_pulse_a: assert property (pin_irq_line_a |=> !pin_irq_line_a)
		else $error("irq line a longer than one cycle");
	irq_b_pulse_a: assert property ($rose(pin_irq_line_b) |=> $fell(pin_irq_line_b))
		else $error("irq line b longer than one cycle");
	adc_analog_a: assert property (adc_d4_connect |-> $past(analog_path_enable[0]))
		else $error("adc connected without analog enable");
	dac_analog_a: assert property (voltage_dac_connect |-> $past(analog_path_enable[10]))
		else $error("dac connected without analog enable");
	cmp_analog_a: assert property (comparator_connect[3] |-> $past(analog_path_enable[3]))
		else $error("comparator connected without analog enable");
endmodule : pfs_pin_mux_asserts

bind pfs_pin_mux pfs_pin_mux_asserts pfs_pin_mux_asserts_inst (.clk, .rst_n, .addr, .rd_en,
	.rd_data, .analog_path_enable, .pad_oe_n, .comparator_connect, .pin_irq_line_a,
	.pin_irq_line_b, .adc_d4_connect, .voltage_dac_connect);
`default_nettype wire

// *** tb/pfs_pin_mux_tb.sv ***
// pfs_pin_mux_tb: self-checking bench for the pin function select block.
// Assumes pads looped through the pad model and a one-cycle read port.
`timescale 1ns/1ps
`default_nettype none
module pfs_pin_mux_tb;
	import pfs_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [PFS_AW-1:0] addr = '0;
	pfs_byte_t wr_data = '0;
	logic wr_en = 1'b0, rd_en = 1'b0, rd_pend = 1'b0;
	logic [PFS_DW-1:0] rd_data;
	pfs_pins_t ana = '0, od = '0, ext = '1, gio_out = '0, gio_drv = '0;
	pfs_pins_t pad_in, pad_out, pad_oe_n, gio_in, cmp;
	logic cc_out = 1'b0, cc_drv = 1'b0, tx = 1'b0;
	logic cc_in, tmr1, tmr0, irq_a, irq_b, irq_d, rx, adc, crystal_input, crystal_output, dac;
	logic [3:0] i2c_out = '0, i2c_drv = '0; // master data, slave data, master clk, slave clk
	wire [3:0] i2c_in;
	int n_errors = 0, comparisons = 0, seed = 29, n, p;
	pfs_byte_t exp_q[$];

	// 200 MHz clock
	always #2.5 clk = ~clk;

	pfs_pin_mux pfs_pin_mux_inst (.clk, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.analog_path_enable(ana), .open_drain_enable(od), .pad_in, .pad_out, .pad_oe_n,
		.general_io_out(gio_out), .general_io_drive(gio_drv), .general_io_in(gio_in),
		.capture_compare_ch1_out(cc_out), .capture_compare_ch1_drive(cc_drv),
		.capture_compare_ch1_in(cc_in), .i2c_master_data_out(i2c_out[3]),
		.i2c_master_data_drive(i2c_drv[3]), .i2c_master_data_in(i2c_in[3]),
		.i2c_slave_data_out(i2c_out[2]), .i2c_slave_data_drive(i2c_drv[2]),
		.i2c_slave_data_in(i2c_in[2]), .i2c_master_clock_out(i2c_out[1]),
		.i2c_master_clock_drive(i2c_drv[1]), .i2c_master_clock_in(i2c_in[1]),
		.i2c_slave_clock_out(i2c_out[0]), .i2c_slave_clock_drive(i2c_drv[0]),
		.i2c_slave_clock_in(i2c_in[0]), .timer1_input(tmr1), .timer0_input(tmr0),
		.pin_irq_line_a(irq_a), .pin_irq_line_b(irq_b), .pin_irq_line_d(irq_d),
		.uart2_transmit(tx), .uart2_receive(rx), .adc_d4_connect(adc),
		.crystal_input_connect(crystal_input), .crystal_output_connect(crystal_output),
		.voltage_dac_connect(dac), .comparator_connect(cmp));

	pfs_pad_model pfs_pad_model_inst (.pad_out, .pad_oe_n, .ext_level(ext), .pad_in);

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// every bus change lands just after a rising edge
	task automatic bus(input logic w, input logic r, input logic [15:0] a, input pfs_byte_t d);
		@(posedge clk);
		wr_en <= w;
		rd_en <= r;
		addr <= a;
		wr_data <= d;
	endtask : bus

	task automatic rd(input logic [15:0] a, input pfs_byte_t e);
		exp_q.push_back(e);
		bus(1'b0, 1'b1, a, 8'h00);
	endtask : rd

	// write, release the strobe, let the pad sync path settle
	// every scenario writes one function bit or none per pin, plus the edge bit for pin interrupts
	task automatic cfg(input int pin, input pfs_byte_t d);
		bus(1'b1, 1'b0, PFS_REG_OFF[pin], d);
		bus(1'b0, 1'b0, PFS_REG_OFF[pin], 8'h00);
		repeat (6) @(posedge clk);
	endtask : cfg

	task automatic done(input string s);
		$display("test %s done", s);
	endtask : done

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// read results against the oldest note
	always @(posedge clk) begin
		if (rd_pend) begin
			if (exp_q.size() == 0)
				check(16'h0001, 16'h0000);
			else
				check(rd_data, exp_q.pop_front());
		end
		rd_pend <= rd_en;
	end

	// a hang ends the run as a failure
	initial begin
		#100us;
		n_errors++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		check(pad_oe_n, 16'h07FF);
		check({gio_in, cc_in, i2c_in, tmr1, tmr0, rx, irq_d}, 16'h0000);
		for (int k = 0; k < PFS_NPIN; k++) rd(PFS_REG_OFF[k], PFS_REG_RST);
		rd(16'hA058, 8'h00);
		rd(16'hA074, 8'h00);
		done("reset");
		// each bit alone, read straight back
		for (int k = 0; k < PFS_NPIN; k++) begin
			for (int b = 0; b < 8; b++) begin
				bus(1'b1, 1'b0, PFS_REG_OFF[k], 8'h01 << b);
				rd(PFS_REG_OFF[k], PFS_REG_MASK[k] & (8'h01 << b));
			end
			bus(1'b1, 1'b0, PFS_REG_OFF[k], 8'h00);
		end
		done("registers");
		gio_drv <= '1;
		gio_out <= pfs_pins_t'($random(seed));
		for (int k = 0; k < PFS_NPIN; k++) cfg(k, 8'h01);
		check(pad_oe_n, 16'h0000);
		check({pad_out, gio_in}, {gio_out, gio_out});
		gio_drv <= '0;
		for (int k = 0; k < PFS_NPIN; k++) cfg(k, 8'h00);
		done("general_io");
		cc_drv <= 1'b1;
		cc_out <= 1'($random(seed));
		cfg(PFS_P1_1, 8'h04);
		check({pad_oe_n[0], pad_out[0], cc_in}, {1'b0, cc_out, cc_out});
		ana <= 11'h001;
		cfg(PFS_P1_1, 8'h02);
		check({adc, pad_oe_n[0]}, 2'b11);
		ana <= '0;
		cfg(PFS_P1_1, 8'h00);
		done("capture_adc");
		od <= 11'h006;
		for (int k = 0; k < 4; k++) begin
			cfg(1 + k / 2, (k % 2) ? 8'h02 : 8'h04);
			check(i2c_in, 4'h8 >> k);
			i2c_drv <= 4'(4'h8 >> k);
			repeat (6) @(posedge clk);
			check({pad_oe_n[1 + k / 2], i2c_in}, 16'h0000);
			i2c_drv <= '0;
			cfg(1 + k / 2, 8'h00);
		end
		done("i2c");
		for (int k = 0; k < 4; k++) begin
			p = PFS_P1_6 + k / 2;
			cfg(p, 8'h08);
			check(p == PFS_P1_6 ? tmr1 : tmr0, 1'b1);
			ext[p] <= 1'b0;
			cfg(p, (k % 2) ? 8'h06 : 8'h02);
			for (int e = 1; e >= 0; e--) begin
				ext[p] <= e[0];
				n = 0;
				repeat (8) begin
					@(posedge clk);
					n += ((p == PFS_P1_6 ? irq_a : irq_b) === 1'b1);
				end
				check(16'(n), 16'((k % 2) == e));
			end
			ext[p] <= 1'b1;
			cfg(p, 8'h00);
		end
		done("timer_irq");
		cfg(PFS_P2_0, 8'h02);
		cfg(PFS_P2_1, 8'h02);
		check({crystal_input, crystal_output}, 2'b11);
		tx <= 1'($random(seed));
		cfg(PFS_P2_2, 8'h02);
		check({pad_oe_n[9], pad_out[9]}, {1'b0, tx});
		cfg(PFS_P2_3, 8'h02);
		check({rx, irq_d}, 2'b11);
		ana <= 11'h408;
		cfg(PFS_P2_3, 8'h80);
		check({dac, cmp}, {1'b1, 11'h008});
		done("analog_misc");
		for (int i = 0; i < 10 && exp_q.size() > 0; i++) @(posedge clk);
		if (exp_q.size() > 0)
			n_errors++;
		complete_run();
	end
endmodule : pfs_pin_mux_tb
`default_nettype wire
